// file: src/sda_params.svh
// register offsets, reset values and counts of the converter back end
`ifndef SDA_PARAMS_SVH
`define SDA_PARAMS_SVH
`define SDA_OFF_STAT   8'h00
`define SDA_OFF_MASK   8'h04
`define SDA_OFF_CLR    8'h08
`define SDA_OFF_MODE   8'h0C
`define SDA_OFF_CTRL   8'h10
`define SDA_OFF_FILT   8'h14
`define SDA_OFF_RES0   8'h18
`define SDA_OFF_RES1   8'h1C
`define SDA_OFF_RES2   8'h20
`define SDA_OFF_CLIM   8'h24
`define SDA_OFF_CVAL   8'h28
`define SDA_OFF_THR    8'h2C
`define SDA_OFF_ACC    8'h30
`define SDA_OFF_HVC    8'h34
`define SDA_RST_CLIM   16'h0001
`define SDA_RST_FILT   32'h0000_0040
`define SDA_BIT_LP     0
`define SDA_BIT_ACCEN  1
`define SDA_BIT_TEXT   2
`define SDA_BIT_ATTEN  7
`define SDA_ST_CNT     3
`define SDA_ST_THR     4
`define SDA_ST_OVR     5
`define SDA_ST_ACCW    6
`define SDA_SETTLE_NOCHOP 2'd3
`define SDA_SETTLE_CHOP   2'd2
`define SDA_LP_FACTOR  4
`endif

// file: src/sda_pkg.sv
// types shared by the converter back end
package sda_pkg;
  typedef enum logic [0:0] {
    SDA_SETTLE = 1'b0,
    SDA_RUN    = 1'b1
  } sda_phase_t;
endpackage

// file: src/sda_sinc3.sv
// sinc3 decimator with settling gate for one channel
`timescale 1ns/1ns
`include "sda_params.svh"
module sda_sinc3
  import sda_pkg::*;
#(
  parameter int DEC_W = 17,
  parameter int ACC_W = 52
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             tick,
  input  wire logic             bit_in,
  input  wire logic             restart,
  input  wire logic             chop,
  input  wire logic [DEC_W-1:0] dec,
  input  wire logic [5:0]       shift,
  output logic      [15:0]      result,
  output logic                  valid,
  output logic                  settled
);
  logic [ACC_W-1:0] i1, i2, i3, z1, z2, z3;
  logic [ACC_W-1:0] d1, d2, d3, scaled;
  logic [ACC_W-1:0] next_i1, next_i2, next_i3;
  logic [DEC_W-1:0] dcnt, dec_m1;
  logic [1:0]       nout, need;
  sda_phase_t       phase;
  logic             dump;

  // comb section sees this tick's sums, so the third output spans
  // a full window of fresh modulator bits after a restart
  always_comb begin
    dec_m1  = (dec == '0) ? '0 : dec - 1'b1;
    dump    = tick && (dcnt == dec_m1);
    next_i1 = i1 + {{(ACC_W-1){1'b0}}, bit_in};
    next_i2 = i2 + next_i1;
    next_i3 = i3 + next_i2;
    d1      = next_i3 - z1;
    d2     = d1 - z2;
    d3     = d2 - z3;
    scaled = d3 >> shift;
    need   = chop ? `SDA_SETTLE_CHOP : `SDA_SETTLE_NOCHOP;
  end

  // integrators, decimation count and combs
  always_ff @(posedge clk) begin
    if (srst || (ce && restart)) begin
      {i1, i2, i3, z1, z2, z3} <= '0;
      dcnt <= '0;
    end else if (ce && tick) begin
      i1   <= next_i1;
      i2   <= next_i2;
      i3   <= next_i3;
      dcnt <= dump ? '0 : dcnt + 1'b1;
      if (dump) begin
        z1 <= next_i3;
        z2 <= d1;
        z3 <= d2;
      end
    end
  end

  // drop outputs until the filter has flushed
  always_ff @(posedge clk) begin
    if (srst || (ce && restart)) begin
      phase  <= SDA_SETTLE;
      nout   <= 2'd0;
      valid  <= 1'b0;
      result <= 16'h0000;
    end else if (ce) begin
      valid <= 1'b0;
      if (dump) begin
        unique case (phase)
          SDA_SETTLE: begin
            nout <= nout + 2'd1;
            if (nout + 2'd1 == need) begin
              phase <= SDA_RUN;
              valid <= 1'b1;
            end
          end
          SDA_RUN: valid <= 1'b1;
        endcase
        result <= (|scaled[ACC_W-1:16]) ? 16'hFFFF : scaled[15:0];
      end
    end
  end
  assign settled = (phase == SDA_RUN);

  settle_gate_a: assert property (@(posedge clk) disable iff (srst)
    $rose(valid) && $past(phase) == SDA_SETTLE |-> $past(nout) == need - 2'd1)
    else $error("result released before settling");
endmodule

// file: src/sda_ovr.sv
// fast overrange: long run of identical modulator bits
`timescale 1ns/1ns
module sda_ovr #(
  parameter int RUN = 32
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic tick,
  input  wire logic bit_in,
  output logic      ovr
);
  logic [$clog2(RUN+1)-1:0] run;
  logic                     last;

  // pulse once when the run length reaches the limit
  always_ff @(posedge clk) begin
    if (srst) begin
      run  <= '0;
      last <= 1'b0;
      ovr  <= 1'b0;
    end else if (ce) begin
      ovr <= 1'b0;
      if (tick) begin
        last <= bit_in;
        if (bit_in != last) begin
          run <= '0;
        end else if (run != RUN[$bits(run)-1:0]) begin
          run <= run + 1'b1;
          ovr <= (run + 1'b1 == RUN[$bits(run)-1:0]);
        end
      end
    end
  end
endmodule

// file: src/sda_top.sv
// sigma-delta back end: three decimators, current extras, apb registers
`timescale 1ns/1ns
`include "sda_params.svh"
module sda_top
  import sda_pkg::*;
#(
  parameter int DEC_W   = 17,
  parameter int MOD_DIV = 244,
  parameter int OVR_RUN = 32
) (
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic        CE,
  input  wire logic [2:0]  MOD_BIT,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  output logic             MOD_CLK,
  output logic             HV_ATTEN_EN,
  output logic             TEMP_SRC_EXT
);
  localparam int DIV_W = $clog2(MOD_DIV * `SDA_LP_FACTOR + 1);
  logic [2:0]       sync1, sync2;
  logic [2:0]       valid, settled, restart;
  logic [15:0]      res [3];
  logic [DIV_W-1:0] div_cnt, div_lim;
  logic             tick, ovr_evt;
  logic [7:0]       stat_lo, mask;
  logic [7:0]       next_stat_lo, set_evt, clr_bits;
  logic [2:0]       mode, ctrl_en, ctrl_chop;
  logic [31:0]      filt;
  logic [15:0]      clim, cval, thr;
  logic [31:0]      acc;
  logic [32:0]      acc_sum;
  logic             atten;
  logic             access, wr, cfg_wr, mapped, src_chg;
  logic [31:0]      rd_val;

  // modulator bits cross from the analog side
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sync1 <= 3'b000;
      sync2 <= 3'b000;
    end else if (CE) begin
      sync1 <= MOD_BIT;
      sync2 <= sync1;
    end
  end

  // modulator clock, slowed down in low power mode
  assign div_lim = mode[`SDA_BIT_LP] ?
                   DIV_W'(MOD_DIV * `SDA_LP_FACTOR - 1) :
                   DIV_W'(MOD_DIV - 1);
  assign tick = (div_cnt == div_lim);
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      div_cnt <= '0;
      MOD_CLK <= 1'b0;
    end else if (CE) begin
      div_cnt <= tick ? '0 : div_cnt + 1'b1;
      if (tick || div_cnt == (div_lim >> 1)) begin
        MOD_CLK <= ~MOD_CLK;
      end
    end
  end

  // apb decode
  assign access = PSEL && PENABLE && PREADY;
  assign wr     = access && PWRITE;
  assign cfg_wr = wr && (PADDR == `SDA_OFF_MODE || PADDR == `SDA_OFF_CTRL ||
                         PADDR == `SDA_OFF_FILT);
  assign src_chg = wr && PADDR == `SDA_OFF_MODE &&
                   PWDATA[`SDA_BIT_TEXT] != mode[`SDA_BIT_TEXT];

  // one decimator per channel, restarted on enable or setup change
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_ch
      assign restart[ch] = !ctrl_en[ch] || cfg_wr || (ch == 2 && src_chg);
      sda_sinc3 #(.DEC_W(DEC_W), .ACC_W(3 * DEC_W + 1)) u_flt (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .ce      (CE),
        .tick    (tick),
        .bit_in  (sync2[ch]),
        .restart (restart[ch]),
        .chop    (ctrl_chop[ch]),
        .dec     (filt[DEC_W-1:0]),
        .shift   (filt[29:24]),
        .result  (res[ch]),
        .valid   (valid[ch]),
        .settled (settled[ch])
      );
    end
  endgenerate

  // held in reset while the channel is off, so no pulse is left standing
  sda_ovr #(.RUN(OVR_RUN)) u_ovr (
    .clk    (CLK_SYS),
    .srst   (SRST || (CE && !ctrl_en[0])),
    .ce     (CE),
    .tick   (tick),
    .bit_in (sync2[0]),
    .ovr    (ovr_evt)
  );

  // result counter, only settled results reach it
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      cval <= 16'h0000;
    end else if (CE && valid[0]) begin
      cval <= (cval + 16'd1 >= clim) ? 16'h0000 : cval + 16'd1;
    end
  end

  // accumulator, cleared while disabled
  assign acc_sum = {1'b0, acc} + {17'h0_0000, res[0]};
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      acc <= 32'h0000_0000;
    end else if (CE) begin
      if (!mode[`SDA_BIT_ACCEN]) begin
        acc <= 32'h0000_0000;
      end else if (valid[0]) begin
        acc <= acc_sum[31:0];
      end
    end
  end

  // event sources of the low status byte
  always_comb begin
    set_evt = 8'h00;
    set_evt[2:0] = valid;
    set_evt[`SDA_ST_CNT]  = valid[0] && (cval + 16'd1 >= clim);
    set_evt[`SDA_ST_THR]  = valid[0] && (res[0] > thr);
    set_evt[`SDA_ST_OVR]  = ovr_evt;
    set_evt[`SDA_ST_ACCW] = valid[0] && mode[`SDA_BIT_ACCEN] &&
                            acc_sum[32];
    clr_bits = (wr && PADDR == `SDA_OFF_CLR) ? PWDATA[7:0] : 8'h00;
    next_stat_lo = (stat_lo & ~clr_bits) | set_evt;
  end

  // sticky status and masked interrupt
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      stat_lo <= 8'h00;
      IRQ     <= 1'b0;
    end else if (CE) begin
      stat_lo <= next_stat_lo;
      IRQ     <= |(stat_lo & mask);
    end
  end

  // software-written configuration
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      mask      <= 8'h00;
      mode      <= 3'b000;
      ctrl_en   <= 3'b000;
      ctrl_chop <= 3'b000;
      filt      <= `SDA_RST_FILT;
      clim      <= `SDA_RST_CLIM;
      thr       <= 16'h0000;
      atten     <= 1'b0;
    end else if (CE && wr) begin
      unique case (PADDR)
        `SDA_OFF_MASK: mask <= PWDATA[7:0];
        `SDA_OFF_MODE: mode <= PWDATA[2:0];
        `SDA_OFF_CTRL: begin
          ctrl_en   <= PWDATA[2:0];
          ctrl_chop <= PWDATA[5:3];
        end
        `SDA_OFF_FILT: filt <= PWDATA;
        `SDA_OFF_CLIM: clim <= PWDATA[15:0];
        `SDA_OFF_THR:  thr  <= PWDATA[15:0];
        `SDA_OFF_HVC:  atten <= PWDATA[`SDA_BIT_ATTEN];
        default: ;
      endcase
    end
  end

  // read multiplexer, high status byte holds live settled flags
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (PADDR)
      `SDA_OFF_STAT: rd_val = {21'h0, settled, stat_lo};
      `SDA_OFF_MASK: rd_val = {24'h0, mask};
      `SDA_OFF_CLR:  rd_val = 32'h0000_0000;
      `SDA_OFF_MODE: rd_val = {29'h0, mode};
      `SDA_OFF_CTRL: rd_val = {26'h0, ctrl_chop, ctrl_en};
      `SDA_OFF_FILT: rd_val = filt;
      `SDA_OFF_RES0: rd_val = {16'h0, res[0]};
      `SDA_OFF_RES1: rd_val = {16'h0, res[1]};
      `SDA_OFF_RES2: rd_val = {16'h0, res[2]};
      `SDA_OFF_CLIM: rd_val = {16'h0, clim};
      `SDA_OFF_CVAL: rd_val = {16'h0, cval};
      `SDA_OFF_THR:  rd_val = {16'h0, thr};
      `SDA_OFF_ACC:  rd_val = acc;
      `SDA_OFF_HVC:  rd_val = {24'h0, atten, 7'h00};
      default:       mapped = 1'b0;
    endcase
  end

  // apb answer: ready one cycle after setup, data caught at setup
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= PSEL && !PENABLE;
      if (PSEL && !PENABLE) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : rd_val;
        PSLVERR <= !mapped;
      end
    end
  end

  // pins steered by configuration bits
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      HV_ATTEN_EN  <= 1'b0;
      TEMP_SRC_EXT <= 1'b0;
    end else if (CE) begin
      HV_ATTEN_EN  <= atten;
      TEMP_SRC_EXT <= mode[`SDA_BIT_TEXT];
    end
  end

  stat_sticky_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    stat_lo[`SDA_ST_THR] && !clr_bits[`SDA_ST_THR] |=> stat_lo[`SDA_ST_THR])
    else $error("threshold flag dropped without clear");
  irq_gate_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CE && |(stat_lo & mask) |=> IRQ)
    else $error("enabled status bit did not raise irq");
  high_flag_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CE && (stat_lo & mask) == 8'h00 |=> !IRQ)
    else $error("irq without enabled low status bit");
  count_hit_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CE && valid[0] && cval + 16'd1 >= clim |=>
      stat_lo[`SDA_ST_CNT] && cval == 16'h0000)
    else $error("count limit not flagged");
  thr_hit_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CE && valid[0] && res[0] > thr |=> stat_lo[`SDA_ST_THR])
    else $error("threshold exceed not flagged");
  acc_sum_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CE && valid[0] && mode[`SDA_BIT_ACCEN] |=>
      acc == $past(acc) + {16'h0, $past(res[0])})
    else $error("accumulator missed a result");
  ovr_flag_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CE && ovr_evt |=> stat_lo[`SDA_ST_OVR])
    else $error("overrange not flagged");
  valid_settled_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    valid[0] |-> settled[0])
    else $error("unsettled result reached extras");
  apb_ready_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CE && PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("apb ready not one cycle after setup");
  cur_result_c: cover property (@(posedge CLK_SYS) disable iff (SRST)
    valid[0]);
  irq_rise_c: cover property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(IRQ));
  ovr_seen_c: cover property (@(posedge CLK_SYS) disable iff (SRST)
    ovr_evt);
  temp_switch_c: cover property (@(posedge CLK_SYS) disable iff (SRST)
    src_chg ##[1:1000] valid[2]);
endmodule

// file: tb/sda_mod_model.sv
// modulator stand-in: bit patterns paced by the modulator clock
`timescale 1ns/1ns
module sda_mod_model (
  input  wire logic       mod_clk,
  input  wire logic [5:0] pat,
  output logic      [2:0] mod_bit
);
  logic flip;

  initial begin
    flip = 1'b0;
    mod_bit = 3'b000;
  end

  // two pattern bits a channel: [1] toggle, else steady level [0]
  always @(posedge mod_clk) begin
    flip <= ~flip;
    for (int i = 0; i < 3; i++) begin
      mod_bit[i] <= pat[2*i+1] ? ~flip : pat[2*i];
    end
  end
endmodule

// file: tb/tb_sda_top.sv
// self-checking bench of the converter back end
`timescale 1ns/1ns
`include "sda_params.svh"
module tb_sda_top;
  logic        clk, srst, ce, psel, penable, pwrite, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, mod_clk, atten, text_src;
  logic [2:0]  mod_bit;
  logic [5:0]  pat;
  int          n_fail, compares, n;

  sda_top #(.MOD_DIV(4), .OVR_RUN(4)) u_sda_top (
    .CLK_SYS(clk), .SRST(srst), .CE(ce), .MOD_BIT(mod_bit),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .MOD_CLK(mod_clk),
    .HV_ATTEN_EN(atten), .TEMP_SRC_EXT(text_src));

  sda_mod_model u_sda_mod_model (
    .mod_clk(mod_clk), .pat(pat), .mod_bit(mod_bit));

  // 125 MHz system clock
  always #4 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h..%h", $time, v, lo, hi);
    end
  endtask

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, `SDA_OFF_STAT, 32'h0000_0000);
      k++;
    end while (rd[b] !== 1'b1 && k < 100);
    if (rd[b] !== 1'b1) n_fail++;
  endtask

  task automatic t_reset();
    rdc(`SDA_OFF_STAT, 32'h0000_0000);
    rdc(`SDA_OFF_MASK, 32'h0000_0000);
    rdc(`SDA_OFF_FILT, `SDA_RST_FILT);
    rdc(`SDA_OFF_CLIM, {16'h0000, `SDA_RST_CLIM});
    rdc(`SDA_OFF_ACC, 32'h0000_0000);
    rdc(8'h38, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
  endtask

  task automatic t_regs();
    wr(`SDA_OFF_MASK, 32'h0000_01A5);
    rdc(`SDA_OFF_MASK, 32'h0000_00A5);
    wr(`SDA_OFF_HVC, 32'h0000_0080);
    repeat (2) @(posedge clk);
    chk({31'h0, atten}, 32'h0000_0001);
    wr(`SDA_OFF_FILT, 32'h0000_0008);
    rdc(`SDA_OFF_FILT, 32'h0000_0008);
  endtask

  // settling: chop off gives the third decimation, chop on the second;
  // every start is timed; a chopped one has its full-scale value read one result later
  task automatic t_settle(input int ch, input int chop);
    int lo;
    wr(`SDA_OFF_CTRL, 32'h0000_0000);
    wr(`SDA_OFF_CLR, 32'hFFFF_FFFF);
    wr(`SDA_OFF_MASK, 32'(1 << ch));
    wr(`SDA_OFF_CTRL, 32'((chop << (3 + ch)) | (1 << ch)));
    wait_irq(300);
    lo = chop ? 56 : 88;
    chk_rng(n, lo, lo + 24);
    if (chop) begin
      wr(`SDA_OFF_CLR, 32'(1 << ch));
      poll(ch);
    end
    apb(1'b0, `SDA_OFF_RES0 + 8'(4 * ch), 32'h0000_0000);
    chk(rd, 32'h0000_0200);
  endtask

  task automatic t_src();
    wr(`SDA_OFF_CLR, 32'hFFFF_FFFF);
    wr(`SDA_OFF_MODE, 32'h0000_0004);
    wait_irq(300);
    chk_rng(n, 88, 112);
    chk({31'h0, text_src}, 32'h0000_0001);
  endtask

  task automatic t_mask();
    wr(`SDA_OFF_MASK, 32'h0000_0000);
    poll(2);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b0, `SDA_OFF_STAT, 32'h0000_0000);
    chk({31'h0, rd[2]}, 32'h0000_0001);
    wr(`SDA_OFF_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`SDA_OFF_MASK, 32'h0000_00FF);
    wr(`SDA_OFF_CLR, 32'h0000_00FF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b0, `SDA_OFF_STAT, 32'h0000_0000);
    chk({31'h0, rd[10]}, 32'h0000_0001);
  endtask

  task automatic t_count();
    wr(`SDA_OFF_CTRL, 32'h0000_0000);
    wr(`SDA_OFF_MODE, 32'h0000_0000);
    wr(`SDA_OFF_CLIM, 32'h0000_0003);
    wr(`SDA_OFF_THR, 32'h0000_01FF);
    wr(`SDA_OFF_MODE, 32'h0000_0002);
    wr(`SDA_OFF_CLR, 32'hFFFF_FFFF);
    wr(`SDA_OFF_CTRL, 32'h0000_0001);
    for (int k = 1; k <= 4; k++) begin
      poll(0);
      wr(`SDA_OFF_CLR, 32'h0000_0001);
      rdc(`SDA_OFF_CVAL, 32'(k % 3));
      rdc(`SDA_OFF_ACC, 32'(512 * k));
      apb(1'b0, `SDA_OFF_STAT, 32'h0000_0000);
      chk({31'h0, rd[3]}, 32'(k >= 3));
      chk({31'h0, rd[4]}, 32'h0000_0001);
    end
    wr(`SDA_OFF_THR, 32'h0000_0200);
    wr(`SDA_OFF_CLR, 32'h0000_0010);
    poll(0);
    chk({31'h0, rd[4]}, 32'h0000_0000);
  endtask

  // toggling stream never overranges, a steady one flags fast
  task automatic t_ovr();
    pat <= 6'b01_01_10;
    wr(`SDA_OFF_CTRL, 32'h0000_0000);
    repeat (40) @(posedge clk);
    wr(`SDA_OFF_CLR, 32'hFFFF_FFFF);
    wr(`SDA_OFF_MASK, 32'h0000_0020);
    wr(`SDA_OFF_CTRL, 32'h0000_0001);
    repeat (150) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    pat <= 6'b01_01_01;
    wait_irq(100);
    chk_rng(n, 1, 31);
  endtask

  task automatic t_per(input int exp);
    longint t0;
    @(posedge mod_clk);
    t0 = $time;
    @(posedge mod_clk);
    chk_rng(int'(($time - t0) / 8), exp, exp);
  endtask

  // clock enable low freezes the modulator clock divider
  task automatic t_ce();
    logic m;
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    m = mod_clk;
    repeat (40) @(posedge clk);
    chk({31'h0, mod_clk}, {31'h0, m});
    ce <= 1'b1;
  endtask

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog against a hung handshake or missing event
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pat = 6'b01_01_01;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_regs();
    t_settle(0, 0);
    t_settle(0, 1);
    t_settle(1, 0);
    t_settle(1, 1);
    t_settle(2, 0);
    t_src();
    t_mask();
    t_count();
    t_ovr();
    t_per(4);
    wr(`SDA_OFF_MODE, 32'h0000_0001);
    t_per(4 * `SDA_LP_FACTOR);
    t_ce();
    give_verdict();
  end
endmodule
